// ### scs_map.svh
// Register offsets, field positions, reset values and response codes of the clock select block
`ifndef SCS_MAP_SVH
`define SCS_MAP_SVH

`define SCS_ADDR_W 8
`define SCS_OFF_SYSCTL 8'h00
`define SCS_OFF_LOOPCTL 8'h04
`define SCS_OFF_MEMCTL 8'h08
`define SCS_OFF_STATUS 8'h0c

`define SCS_SEL_LSB 0
`define SCS_SEL_MSB 1
`define SCS_BYP_BIT 0
`define SCS_INTSRC_BIT 1
`define SCS_DIV_LSB 16
`define SCS_DIV_MSB 25
`define SCS_WS_LSB 0
`define SCS_WS_MSB 2
`define SCS_PEND_BIT 4

`define SCS_SEL_RST 2'h0
`define SCS_BYP_RST 1'h1
`define SCS_INTSRC_RST 1'h1
`define SCS_DIV_RST 10'h000
`define SCS_WS_RST 3'h4

`define SCS_RESP_OKAY 2'h0
`define SCS_RESP_SLVERR 2'h2

`endif

// ### scs_pkg.sv
// Types shared by the clock select block
package scs_pkg;
    typedef enum logic [1:0] {
        SCS_SRC_WAKEUP = 2'b00,
        SCS_SRC_RSVD = 2'b01,
        SCS_SRC_PRESC = 2'b10,
        SCS_SRC_DIRECT = 2'b11
    } scs_src_t;
    typedef logic [9:0] scs_div_t;
    typedef logic [2:0] scs_ws_t;
endpackage

// ### scs_sync.sv
// Two-stage synchroniser for a group of asynchronous pin levels
`timescale 1ns/1ps
module scs_sync #(
    parameter int W = 1
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            meta_r <= '0;
            sync_out <= '0;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule

// ### scs_top.sv
// System clock source select, prescaler and flash wait-state control with AXI4-Lite registers
// Notes on behaviour
// RULE1 - Select 11 drives clock from direct input
// RULE2 - Select 10 with bypass uses oscillator prescaler
// RULE3 - Division factor is divider setting plus one
// RULE4 - Factor one passes oscillator with its duty
// RULE5 - Prescaler divides by up to 1024
// RULE6 - Bypass crystal, factor one, acts like direct
// RULE7 - Software sets wait states from clock frequency
// RULE8 - Wait states delay only non-sequential flash accesses
// RULE9 - Select 10 without bypass runs the PLL
// RULE10 - Select 00 takes the wakeup clock
// RULE11 - Source or divider switches never truncate pulses
//
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "scs_map.svh"
module scs_top (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [`SCS_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`SCS_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic direct_clock_input,
    input wire logic crystal_input,
    input wire logic internal_clock_input,
    input wire logic wakeup_clock_input,
    input wire logic pll_clock_input,
    input wire logic flash_req,
    input wire logic flash_seq,
    output logic flash_ready,
    output logic [2:0] flash_wait_count,
    output logic pll_enable,
    output logic sys_clk
);
    import scs_pkg::*;

    // Bus and register state
    logic [`SCS_ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
    logic aw_have_r, aw_have_nxt;
    logic [31:0] w_data_r, w_data_nxt;
    logic [3:0] w_strb_r, w_strb_nxt;
    logic w_have_r, w_have_nxt;
    logic awready_nxt, wready_nxt, bvalid_nxt, arready_nxt, rvalid_nxt;
    logic [1:0] bresp_nxt, rresp_nxt;
    logic [31:0] rdata_nxt;
    scs_src_t sel_r, sel_nxt;
    logic byp_r, byp_nxt, intsrc_r, intsrc_nxt;
    scs_div_t div_r, div_nxt;
    scs_ws_t ws_r, ws_nxt;

    // Clock path state
    scs_src_t act_sel_r, act_sel_nxt;
    logic act_byp_r, act_byp_nxt, act_int_r, act_int_nxt;
    scs_div_t act_div_r, act_div_nxt, cnt_r, cnt_nxt;
    logic sys_nxt, arm_r, arm_nxt, src_prev_r, prev_nxt, pll_en_nxt;

    // Flash state
    scs_ws_t fl_cnt_r, fl_cnt_nxt;
    logic fl_busy_r, fl_busy_nxt, fl_rdy_nxt;

    logic [4:0] pins_sync;
    logic src_lv, src_rise, divided, cfg_diff, pend;
    logic [31:0] wmask, loop_word, rd_word;
    logic rd_ok;

    // Every pin clock is sampled; sources must stay well below half of clk_sys
    scs_sync #(.W(5)) u_sync (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .async_in({pll_clock_input, wakeup_clock_input, internal_clock_input,
                   crystal_input, direct_clock_input}),
        .sync_out(pins_sync)
    );

    always_comb begin
        src_lv = 1'b0;
        unique case (act_sel_r)
            SCS_SRC_DIRECT: src_lv = pins_sync[0]; // [RULE1]
            SCS_SRC_PRESC: begin
                if (act_byp_r) begin
                    src_lv = act_int_r ? pins_sync[2] : pins_sync[1]; // [RULE2] [RULE6]
                end else begin
                    src_lv = pins_sync[4]; // [RULE9]
                end
            end
            SCS_SRC_WAKEUP: src_lv = pins_sync[3]; // [RULE10]
            SCS_SRC_RSVD: src_lv = 1'b0;
        endcase
    end

    assign src_rise = src_lv & ~src_prev_r;
    assign divided = (act_sel_r == SCS_SRC_PRESC) && act_byp_r && (act_div_r != '0);
    assign cfg_diff = (sel_r != act_sel_r) || (byp_r != act_byp_r) ||
                      (intsrc_r != act_int_r) || (div_r != act_div_r);
    assign pend = cfg_diff | arm_r;

    always_comb begin
        act_sel_nxt = act_sel_r;
        act_byp_nxt = act_byp_r;
        act_int_nxt = act_int_r;
        act_div_nxt = act_div_r;
        cnt_nxt = cnt_r;
        arm_nxt = arm_r;
        sys_nxt = sys_clk;
        prev_nxt = src_lv;
        if (arm_r) begin
            // After a switch, start only on a clean rising edge of the new source
            sys_nxt = 1'b0;
            if (src_rise) begin
                arm_nxt = 1'b0;
                sys_nxt = 1'b1; // [RULE11]
                cnt_nxt = '0;
            end
        end else if (divided) begin
            if (src_rise) begin
                cnt_nxt = (cnt_r == act_div_r) ? '0 : cnt_r + 10'h001; // [RULE3] [RULE5]
                sys_nxt = (cnt_nxt <= {1'b0, act_div_r[9:1]});
            end
        end else begin
            sys_nxt = src_lv; // [RULE4]
        end
        // Change over only in a low phase (divided: at its end), so no high pulse is cut
        if (cfg_diff && !sys_clk &&
            (divided ? (src_rise && cnt_r == act_div_r) : !src_lv)) begin
            act_sel_nxt = sel_r; // [RULE11]
            act_byp_nxt = byp_r;
            act_int_nxt = intsrc_r;
            act_div_nxt = div_r;
            arm_nxt = 1'b1;
            sys_nxt = 1'b0;
            cnt_nxt = '0;
            // New source must be seen low first, else a mid-pulse start
            prev_nxt = 1'b1; // [RULE11]
        end
        pll_en_nxt = (act_sel_nxt == SCS_SRC_PRESC) && !act_byp_nxt; // [RULE9]
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            act_sel_r <= SCS_SRC_WAKEUP;
            act_byp_r <= `SCS_BYP_RST;
            act_int_r <= `SCS_INTSRC_RST;
            act_div_r <= `SCS_DIV_RST;
            cnt_r <= '0;
            arm_r <= 1'b1;
            sys_clk <= 1'b0;
            src_prev_r <= 1'b1;
            pll_enable <= 1'b0;
        end else begin
            act_sel_r <= act_sel_nxt;
            act_byp_r <= act_byp_nxt;
            act_int_r <= act_int_nxt;
            act_div_r <= act_div_nxt;
            cnt_r <= cnt_nxt;
            arm_r <= arm_nxt;
            sys_clk <= sys_nxt;
            src_prev_r <= prev_nxt;
            pll_enable <= pll_en_nxt;
        end
    end

    // Sequential accesses are answered the next cycle and skip the wait states
    always_comb begin
        fl_cnt_nxt = fl_cnt_r;
        fl_busy_nxt = fl_busy_r;
        fl_rdy_nxt = 1'b0;
        if (fl_busy_r) begin
            if (fl_cnt_r <= 3'h1) begin
                fl_busy_nxt = 1'b0;
                fl_rdy_nxt = 1'b1;
            end else begin
                fl_cnt_nxt = fl_cnt_r - 3'h1;
            end
        end else if (flash_req) begin
            if (flash_seq || ws_r == '0) begin
                fl_rdy_nxt = 1'b1; // [RULE8]
            end else begin
                fl_busy_nxt = 1'b1; // [RULE8]
                fl_cnt_nxt = ws_r;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            fl_cnt_r <= '0;
            fl_busy_r <= 1'b0;
            flash_ready <= 1'b0;
            flash_wait_count <= `SCS_WS_RST;
        end else begin
            fl_cnt_r <= fl_cnt_nxt;
            fl_busy_r <= fl_busy_nxt;
            flash_ready <= fl_rdy_nxt;
            flash_wait_count <= ws_r;
        end
    end

    // Register read view
    always_comb begin
        wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
        loop_word = '0;
        loop_word[`SCS_BYP_BIT] = byp_r;
        loop_word[`SCS_INTSRC_BIT] = intsrc_r;
        loop_word[`SCS_DIV_MSB:`SCS_DIV_LSB] = div_r;
        rd_word = '0;
        rd_ok = 1'b1;
        unique case (s_axi_araddr)
            `SCS_OFF_SYSCTL: rd_word[`SCS_SEL_MSB:`SCS_SEL_LSB] = sel_r;
            `SCS_OFF_LOOPCTL: rd_word = loop_word;
            `SCS_OFF_MEMCTL: rd_word[`SCS_WS_MSB:`SCS_WS_LSB] = ws_r;
            `SCS_OFF_STATUS: begin
                rd_word[`SCS_SEL_MSB:`SCS_SEL_LSB] = act_sel_r;
                rd_word[`SCS_PEND_BIT] = pend;
                rd_word[`SCS_DIV_MSB:`SCS_DIV_LSB] = act_div_r;
            end
            default: rd_ok = 1'b0;
        endcase
    end

    always_comb begin
        aw_addr_nxt = aw_addr_r;
        aw_have_nxt = aw_have_r;
        w_data_nxt = w_data_r;
        w_strb_nxt = w_strb_r;
        w_have_nxt = w_have_r;
        bvalid_nxt = s_axi_bvalid;
        bresp_nxt = s_axi_bresp;
        rvalid_nxt = s_axi_rvalid;
        rresp_nxt = s_axi_rresp;
        rdata_nxt = s_axi_rdata;
        sel_nxt = sel_r;
        byp_nxt = byp_r;
        intsrc_nxt = intsrc_r;
        div_nxt = div_r;
        ws_nxt = ws_r;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_addr_nxt = s_axi_awaddr;
            aw_have_nxt = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_data_nxt = s_axi_wdata;
            w_strb_nxt = s_axi_wstrb;
            w_have_nxt = 1'b1;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (aw_have_r && w_have_r && !s_axi_bvalid) begin
            aw_have_nxt = 1'b0;
            w_have_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = `SCS_RESP_OKAY;
            unique case (aw_addr_r)
                `SCS_OFF_SYSCTL: begin
                    if (w_strb_r[0]) begin
                        sel_nxt = scs_src_t'(w_data_r[`SCS_SEL_MSB:`SCS_SEL_LSB]);
                    end
                end
                `SCS_OFF_LOOPCTL: begin
                    if (w_strb_r[0]) begin
                        byp_nxt = w_data_r[`SCS_BYP_BIT];
                        intsrc_nxt = w_data_r[`SCS_INTSRC_BIT];
                    end
                    div_nxt = (w_data_r[`SCS_DIV_MSB:`SCS_DIV_LSB] &
                               wmask[`SCS_DIV_MSB:`SCS_DIV_LSB]) |
                              (div_r & ~wmask[`SCS_DIV_MSB:`SCS_DIV_LSB]);
                end
                `SCS_OFF_MEMCTL: begin
                    if (w_strb_r[0]) begin
                        ws_nxt = w_data_r[`SCS_WS_MSB:`SCS_WS_LSB]; // [RULE7]
                    end
                end
                `SCS_OFF_STATUS: bresp_nxt = `SCS_RESP_OKAY;
                default: bresp_nxt = `SCS_RESP_SLVERR;
            endcase
        end
        if (s_axi_rvalid && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_nxt = 1'b1;
            rdata_nxt = rd_word;
            rresp_nxt = rd_ok ? `SCS_RESP_OKAY : `SCS_RESP_SLVERR;
        end
        awready_nxt = !aw_have_nxt;
        wready_nxt = !w_have_nxt;
        arready_nxt = !rvalid_nxt;
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            aw_addr_r <= '0;
            aw_have_r <= 1'b0;
            w_data_r <= '0;
            w_strb_r <= '0;
            w_have_r <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SCS_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `SCS_RESP_OKAY;
            s_axi_rdata <= '0;
            sel_r <= SCS_SRC_WAKEUP;
            byp_r <= `SCS_BYP_RST;
            intsrc_r <= `SCS_INTSRC_RST;
            div_r <= `SCS_DIV_RST;
            ws_r <= `SCS_WS_RST;
        end else begin
            aw_addr_r <= aw_addr_nxt;
            aw_have_r <= aw_have_nxt;
            w_data_r <= w_data_nxt;
            w_strb_r <= w_strb_nxt;
            w_have_r <= w_have_nxt;
            s_axi_awready <= awready_nxt;
            s_axi_wready <= wready_nxt;
            s_axi_bvalid <= bvalid_nxt;
            s_axi_bresp <= bresp_nxt;
            s_axi_arready <= arready_nxt;
            s_axi_rvalid <= rvalid_nxt;
            s_axi_rresp <= rresp_nxt;
            s_axi_rdata <= rdata_nxt;
            sel_r <= sel_nxt;
            byp_r <= byp_nxt;
            intsrc_r <= intsrc_nxt;
            div_r <= div_nxt;
            ws_r <= ws_nxt;
        end
    end
endmodule

// ### scs_top_props.sv
// Concurrent checks on the clock select block ports
`timescale 1ns/1ps
module scs_top_props (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic flash_req,
    input wire logic flash_seq,
    input wire logic flash_ready,
    input wire logic [2:0] flash_wait_count,
    input wire logic sys_clk
);
    logic busy_r;
    logic [3:0] cnt_r;
    logic [3:0] exp_r;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // Expected delay fixed at acceptance; wait count read at that edge
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            busy_r <= 1'b0;
            cnt_r <= 4'h0;
            exp_r <= 4'h0;
        end else if (flash_req && (!busy_r || flash_ready)) begin
            busy_r <= 1'b1;
            cnt_r <= 4'h1;
            exp_r <= (flash_seq || flash_wait_count == 3'h0) ? 4'h1 :
                     {1'b0, flash_wait_count} + 4'h1;
        end else if (flash_ready) begin
            busy_r <= 1'b0;
        end else if (busy_r) begin
            cnt_r <= cnt_r + 4'h1;
        end
    end
    ready_due_a: assert property (flash_ready |-> busy_r && cnt_r == exp_r)
        else $error("flash ready at wrong cycle");
    wait_bound_a: assert property (busy_r |-> cnt_r <= exp_r)
        else $error("flash access overran its wait states");
    ready_pulse_a: assert property (flash_ready |=> !flash_ready)
        else $error("flash ready longer than one cycle");
    clk_high_min_a: assert property ($rose(sys_clk) |=> sys_clk)
        else $error("truncated high pulse on system clock");
    clk_low_min_a: assert property ($fell(sys_clk) |=> !sys_clk)
        else $error("truncated low phase on system clock");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer missing");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before ready");
    wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before ready");
    cover property (flash_ready && exp_r > 4'h1);
    cover property ($rose(sys_clk));
    cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule

bind scs_top scs_top_props chk_u (.clk_sys(clk_sys), .reset_n(reset_n),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .flash_req(flash_req),
    .flash_seq(flash_seq), .flash_ready(flash_ready), .flash_wait_count(flash_wait_count),
    .sys_clk(sys_clk));

// ### test_system_clock_select_prescaler.sv
// Self-checking bench for the clock select block
`timescale 1ns/1ps
module test_system_clock_select_prescaler;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, flash_ready, pll_enable, sys_clk;
    logic [1:0] bresp, rresp;
    logic [2:0] flash_wait_count;
    logic dir_in = 0, xtal_in = 0, int_in = 0, wu_in = 0, pll_in = 0, flash_req = 0, flash_seq = 0;
    int t = 0;
    int n_fail = 0;
    int tests_run = 0;
    always #2.5 clk_sys = ~clk_sys;
    // Sources locked to clk_sys so widths come out exact after the syncs
    always @(posedge clk_sys) begin
        t <= t + 1;
        dir_in <= (t % 6) < 2;
        xtal_in <= (t % 8) < 3;
        int_in <= (t % 10) < 5;
        wu_in <= (t % 12) < 6;
        pll_in <= (t % 8) < 5;
    end
    scs_top dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .direct_clock_input(dir_in), .crystal_input(xtal_in), .internal_clock_input(int_in),
        .wakeup_clock_input(wu_in), .pll_clock_input(pll_in), .flash_req(flash_req),
        .flash_seq(flash_seq), .flash_ready(flash_ready), .flash_wait_count(flash_wait_count),
        .pll_enable(pll_enable), .sys_clk(sys_clk));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("Counts: %0d compares, %0d mismatches", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Response ready stays up between transfers; only the watchdog ends a wait
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw, w;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        aw = 1'b1;
        w = 1'b1;
        while (aw || w) begin
            @(posedge clk_sys);
            if (aw && awready === 1'b1) begin
                aw = 1'b0;
                awvalid <= 1'b0;
            end
            if (w && wready === 1'b1) begin
                w = 1'b0;
                wvalid <= 1'b0;
            end
        end
        do begin
            @(posedge clk_sys);
        end while (bvalid !== 1'b1);
        chk(bresp, er);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (arready !== 1'b1);
        arvalid <= 1'b0;
        do begin
            @(posedge clk_sys);
        end while (rvalid !== 1'b1);
        chk(rdata, ed);
        chk(rresp, er);
    endtask
    // Skips a settling pulse, then times one full high and low phase
    task automatic meas(input int hi, input int lo);
        int h, l, n, k;
        h = 0;
        l = 0;
        n = 0;
        for (k = 0; k < 4; k++) begin
            while (sys_clk !== k[0] && n < 40000) begin
                @(negedge clk_sys);
                n++;
            end
        end
        while (sys_clk === 1'b1 && n < 40000) begin
            @(negedge clk_sys);
            n++;
            h++;
        end
        while (sys_clk === 1'b0 && n < 40000) begin
            @(negedge clk_sys);
            n++;
            l++;
        end
        chk(h, hi);
        chk(l, lo);
        @(posedge clk_sys);
    endtask
    task automatic fl(input logic seq, input int exp);
        int n;
        flash_req <= 1'b1;
        flash_seq <= seq;
        @(posedge clk_sys);
        flash_req <= 1'b0;
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (flash_ready !== 1'b1 && n < 50);
        chk(n, exp);
        @(posedge clk_sys);
    endtask
    initial begin
        #300000;
        n_fail++;
        final_report();
    end
    initial begin
        repeat (8) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(flash_wait_count, 32'h4);
        chk({pll_enable, sys_clk}, 32'h0);
        @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        rd(8'h00, 32'h0, 2'h0);
        rd(8'h04, 32'h3, 2'h0);
        rd(8'h08, 32'h4, 2'h0);
        rd(8'h10, 32'h0, 2'h2);
        meas(6, 6);
        wr(8'h10, 32'h3, 2'h2);
        wr(8'h00, 32'h3, 2'h0);
        meas(2, 4);
        wr(8'h04, 32'h1, 2'h0);
        wr(8'h00, 32'h2, 2'h0);
        meas(3, 5);
        chk(pll_enable, 32'h0);
        wr(8'h04, 32'h0002_0003, 2'h0);
        meas(20, 10);
        rd(8'h0c, 32'h0002_0002, 2'h0);
        wr(8'h04, 32'h03ff_0003, 2'h0);
        meas(5120, 5120);
        wr(8'h04, 32'h0, 2'h0);
        meas(5, 3);
        chk(pll_enable, 32'h1);
        fl(1'b0, 5);
        fl(1'b1, 1);
        wr(8'h08, 32'h2, 2'h0);
        @(negedge clk_sys);
        chk(flash_wait_count, 32'h2);
        @(posedge clk_sys);
        fl(1'b0, 3);
        wr(8'h08, 32'h0, 2'h0);
        fl(1'b0, 1);
        final_report();
    end
endmodule
